// ### dv/rcs_pin_model.sv
`default_nettype none
module rcs_pin_model (
	input  wire logic i_pull_low,
	input  wire logic i_dev_d,
	input  wire logic i_dev_oe_n,
	output logic      o_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	// outside party pulls
	// wire-and with pull-up, so a released pin reads high
	assign o_pin = !i_pull_low && (i_dev_oe_n || i_dev_d);
endmodule // rcs_pin_model
`default_nettype wire

// ### dv/rcs_sequencer_chk.sv
`default_nettype none
module rcs_sequencer_chk
	import rcs_pkg::*;
(
	input wire logic         i_mclk,
	input wire logic         i_nrst,
	input wire rcs_apb_req_t i_apb,
	input wire rcs_apb_rsp_t o_apb,
	input wire rcs_sys_in_t  i_sys,
	input wire rcs_sys_out_t o_sys,
	input wire logic         i_rst_pin,
	input wire logic         o_rst_pin,
	input wire logic         o_rst_pin_oe_n
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_nrst);
	a_apb_answer: assert property (i_apb.psel && i_apb.penable &&
		!o_apb.pready |=> o_apb.pready ##1 !o_apb.pready)
		else $error("apb answer not one wait state");
	a_bus_quarter: assert property (o_sys.bus_clk_en
		|=> !o_sys.bus_clk_en [*3]) else $error("bus pulse too often");
	a_reset_clocks: assert property (o_sys.internal_reset |->
		!o_sys.cpu_clk_en && o_sys.clkgen_output_en)
		else $error("clocks wrong in reset");
	a_wait_cpu: assert property (o_sys.cpu_clk_en && i_sys.wait_exec
		|-> ##[1:2] (!o_sys.cpu_clk_en &&
		o_sys.periph_clk_en == i_sys.periph_wait_active))
		else $error("wait clocks wrong");
	a_src_reset: assert property (o_sys.cpu_clk_en &&
		i_sys.bad_opcode |=> o_sys.internal_reset && !o_rst_pin_oe_n)
		else $error("opcode reset missing");
	// low supply and power-on take the long path instead
	a_pin_drive: assert property ($rose(o_sys.internal_reset) &&
		!o_rst_pin_oe_n && !$past(i_sys.low_supply) &&
		!$past(i_sys.power_on_pulse) |-> ##31 !o_rst_pin_oe_n
		##1 (o_rst_pin_oe_n && o_sys.internal_reset)
		##31 o_sys.internal_reset ##1 !o_sys.internal_reset)
		else $error("pin drive or hold length wrong");
	a_pin_halt: assert property ($fell(i_rst_pin) &&
		o_sys.cpu_clk_en |-> ##[1:4] o_sys.internal_reset)
		else $error("pin low did not halt");
	a_brk_clear: assert property (o_sys.internal_reset [*2]
		|-> !o_sys.break_clear_en) else $error("break_flag_clear_enable kept in reset");
	a_vector: assert property (o_sys.internal_reset &&
		$stable(i_sys.monitor_mode) |-> o_sys.reset_vector ==
		(i_sys.monitor_mode ? VEC_MON : VEC_USER))
		else $error("reset vector wrong");
endmodule // rcs_sequencer_chk
bind rcs_sequencer rcs_sequencer_chk rcs_sequencer_chk_i (.i_mclk, .i_nrst,
	.i_apb, .o_apb, .i_sys, .o_sys, .i_rst_pin, .o_rst_pin, .o_rst_pin_oe_n);
`default_nettype wire

// ### dv/rcs_sequencer_tb.sv
`default_nettype none
module rcs_sequencer_tb;
	import rcs_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	// short long count keeps the run brief
	localparam int L = 64;
	typedef struct {logic w; logic [15:0] a; logic [7:0] d; logic [8:0] e;}
		rcs_row_t;
	logic         clk, nrst, ext_low, pin, pin_d, pin_oe_n, err;
	rcs_apb_req_t req;
	rcs_apb_rsp_t rsp;
	rcs_sys_in_t  si;
	rcs_sys_out_t so;
	logic [31:0]  rd;
	int           n_mismatch, n_compared, k;
	int           cyc = 0;
	// write rows are not compared; e holds {pslverr, data}
	rcs_row_t rows[9] = '{'{1, IDX_SYS_CFG, 8'h07, 9'h0},
		'{0, IDX_SYS_CFG, 8'h0, 9'h007}, '{1, IDX_RST_CAUSE, 8'hFF, 9'h0},
		'{0, IDX_RST_CAUSE, 8'h0, 9'h080}, '{1, IDX_BRK_CTRL, 8'h80, 9'h0},
		'{0, IDX_BRK_CTRL, 8'h0, 9'h080}, '{0, IDX_BRK_STATUS, 8'h0, 9'h0},
		'{0, 16'hFE04, 8'h0, 9'h100}, '{1, IDX_SYS_CFG, 8'h0, 9'h0}};
	rcs_sequencer #(.LONG_CYCLES(L)) rcs_sequencer_i (.i_mclk(clk),
		.i_nrst(nrst), .i_apb(req), .o_apb(rsp), .i_sys(si), .o_sys(so),
		.i_rst_pin(pin), .o_rst_pin(pin_d), .o_rst_pin_oe_n(pin_oe_n));
	rcs_pin_model rcs_pin_model_i (.i_pull_low(ext_low), .i_dev_d(pin_d),
		.i_dev_oe_n(pin_oe_n), .o_pin(pin));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_mismatch++;
			tally_and_finish();
		end
	end
	task chk(input logic [32:0] g, input logic [32:0] e);
		n_compared++;
		if (g !== e) begin
			n_mismatch++;
			$display("CHECK FAILED %0t got %h exp %h", $time, g, e);
		end
	endtask
	// request held until pready is sampled high at a rising edge;
	// answer taken and request dropped at that same edge
	task apb(input logic w, input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		req <= '{1'b1, 1'b0, w, {14'h0, a, 2'h0}, {24'h0, d}};
		@(posedge clk);
		req.penable <= 1'b1;
		k = 0;
		do @(posedge clk); while (rsp.pready !== 1'b1 && ++k < 20);
		rd = rsp.prdata;
		err = rsp.pslverr;
		req <= '0;
	endtask
	task pulse(input logic [11:0] m);
		@(posedge clk) si <= si | m;
		@(posedge clk) si <= si & ~m;
	endtask
	// waits for the cpu clock; k ends as the cycle count
	task wrun;
		k = 0;
		do @(negedge clk); while (so.cpu_clk_en !== 1'b1 && ++k < 6000);
	endtask
	task rdc(input logic [7:0] e);
		apb(1'b0, IDX_RST_CAUSE, 8'h0);
		chk({1'b0, rd}, {25'h0, e});
	endtask
	task tally_and_finish;
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		nrst = 1'b0;
		ext_low = 1'b0;
		req = '0;
		si = '0;
		n_mismatch = 0;
		n_compared = 0;
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		wrun();
		chk(33'(k inside {[L + 63 : L + 67]}), 33'h1);
		chk(33'(so.reset_vector), 33'(VEC_USER));
		foreach (rows[i]) begin
			apb(rows[i].w, rows[i].a, rows[i].d);
			if (!rows[i].w)
				chk({err, rd}, {rows[i].e[8], 24'h0, rows[i].e[7:0]});
		end
		chk(33'(so.break_clear_en), 33'h1);
		$display("register table done");
		pulse(12'h004);
		apb(1'b0, IDX_BRK_STATUS, 8'h0);
		chk({1'b0, rd}, 33'h2);
		apb(1'b1, IDX_BRK_STATUS, 8'h0);
		apb(1'b0, IDX_BRK_STATUS, 8'h0);
		chk({1'b0, rd}, 33'h0);
		si.periph_wait_active <= 1'b1;
		pulse(12'h040);
		repeat (4) @(negedge clk);
		chk(33'({so.cpu_clk_en, so.periph_clk_en}), 33'h1);
		pulse(12'h008);
		wrun();
		$display("break flag and wait done");
		apb(1'b1, IDX_SYS_CFG, 8'h01);
		pulse(12'h200);
		repeat (4) @(negedge clk);
		chk(33'(so.internal_reset), 33'h0);
		apb(1'b1, IDX_SYS_CFG, 8'h00);
		si.monitor_mode <= 1'b1;
		pulse(12'h200);
		wrun();
		rdc(8'hA0);
		chk(33'(so.reset_vector), 33'(VEC_MON));
		chk(33'(so.break_clear_en), 33'h0);
		pulse(12'h010);
		repeat (4) @(negedge clk);
		chk(33'(so.internal_reset), 33'h0);
		pulse(12'h030);
		wrun();
		rdc(8'hA8);
		pulse(12'h080);
		wrun();
		rdc(8'hB8);
		// decoded bad opcode: 32 drive plus 32 hold cycles
		pulse(12'h100);
		wrun();
		chk(33'(k inside {[62 : 66]}), 33'h1);
		$display("internal sources done");
		@(posedge clk) ext_low <= 1'b1;
		repeat (70) @(posedge clk);
		ext_low <= 1'b0;
		wrun();
		rdc(8'hF8);
		apb(1'b1, IDX_SYS_CFG, 8'h06);
		pulse(12'h080);
		repeat (4) @(negedge clk);
		chk(33'(so.cpu_clk_en), 33'h0);
		pulse(12'h008);
		wrun();
		chk(33'(k inside {[28 : 36]}), 33'h1);
		$display("pin and stop done");
		pulse(12'h400);
		wrun();
		rdc(8'hFA);
		pulse(12'h800);
		wrun();
		rdc(8'h80);
		$display("supply resets done");
		tally_and_finish();
	end
endmodule // rcs_sequencer_tb
`default_nettype wire

// ### src/rcs_pkg.sv
`default_nettype none
package rcs_pkg;
	// register indices; byte address is four times the index
	localparam logic [15:0] IDX_BRK_STATUS = 16'hFE00;
	localparam logic [15:0] IDX_RST_CAUSE  = 16'hFE01;
	localparam logic [15:0] IDX_BRK_CTRL   = 16'hFE02;
	localparam logic [15:0] IDX_SYS_CFG    = 16'hFE03;

	// reset cause fields
	localparam int CAUSE_POR  = 7;
	localparam int CAUSE_PIN  = 6;
	localparam int CAUSE_WDOG = 5;
	localparam int CAUSE_OPC  = 4;
	localparam int CAUSE_ADR  = 3;
	localparam int CAUSE_LVS  = 1;
	// break status and control fields
	localparam int BRK_SW_BIT   = 1;
	localparam int BRK_CFE_BIT  = 7;
	// system configuration fields
	localparam int CFG_WDOG_DIS = 0;
	localparam int CFG_SHORT_SR = 1;
	localparam int CFG_STOP_EN  = 2;
	localparam logic [2:0] CFG_RESET = 3'h0;

	// cycle counts of the source clock
	localparam int LONG_CYC     = 4096;
	localparam int SHORT_CYC    = 32;
	localparam int PIN_DRV_CYC  = 32;
	localparam int RST_HOLD_CYC = 32;
	localparam int PIN_QUAL_CYC = 67;
	localparam logic [1:0] BUS_DIV_LAST = 2'h3;

	// reset vectors
	localparam logic [15:0] VEC_USER = 16'hFFFE;
	localparam logic [15:0] VEC_MON  = 16'hFEFE;

	typedef enum logic [3:0] {
		RCS_LONG, RCS_DRIVE, RCS_HOLD, RCS_EXT, RCS_RUN,
		RCS_WAIT, RCS_STOP, RCS_STOPREC
	} rcs_state_t;

	// apb request and answer
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [31:0] paddr;
		logic [31:0] pwdata;
	} rcs_apb_req_t;

	typedef struct packed {
		logic        pready;
		logic [31:0] prdata;
		logic        pslverr;
	} rcs_apb_rsp_t;

	// requests from cpu, supply monitors and watchdog
	typedef struct packed {
		logic power_on_pulse;
		logic low_supply;
		logic watchdog_ovf;
		logic bad_opcode;
		logic stop_exec;
		logic wait_exec;
		logic opcode_fetch;
		logic unmapped_addr;
		logic wake;
		logic stop_wait_break;
		logic monitor_mode;
		logic periph_wait_active;
	} rcs_sys_in_t;

	// clocking and reset controls to the chip
	typedef struct packed {
		logic        internal_reset;
		logic        cpu_clk_en;
		logic        periph_clk_en;
		logic        bus_clk_en;
		logic        clkgen_output_en;
		logic        break_clear_en;
		logic [15:0] reset_vector;
	} rcs_sys_out_t;
endpackage
`default_nettype wire

// ### src/rcs_sequencer.sv
// Chosen here: the APB slave port.
`default_nettype none
module rcs_sequencer
	import rcs_pkg::*;
#(
	parameter int LONG_CYCLES = LONG_CYC
) (
	input  wire logic         i_mclk,
	input  wire logic         i_nrst,
	input  wire rcs_apb_req_t i_apb,
	output var  rcs_apb_rsp_t o_apb,
	input  wire rcs_sys_in_t  i_sys,
	output var  rcs_sys_out_t o_sys,
	input  wire logic         i_rst_pin,
	output logic              o_rst_pin,
	output logic              o_rst_pin_oe_n
);
	// the 12-bit counter cannot serve longer waits
	if (LONG_CYCLES < SHORT_CYC || LONG_CYCLES > LONG_CYC) begin : g_chk
		$error("LONG_CYCLES out of range");
	end

	localparam logic [11:0] LONG_LAST  = 12'(LONG_CYCLES - 1);
	localparam logic [11:0] SHORT_LAST = 12'(SHORT_CYC - 1);
	localparam logic [5:0]  DRV_LAST   = 6'(PIN_DRV_CYC - 1);
	localparam logic [5:0]  HOLD_LAST  = 6'(RST_HOLD_CYC - 1);
	localparam logic [6:0]  QUAL_CNT   = 7'(PIN_QUAL_CYC);
	localparam logic [31:0] ADDR_BRK = {14'h0000, IDX_BRK_STATUS, 2'h0};
	localparam logic [31:0] ADDR_RC  = {14'h0000, IDX_RST_CAUSE, 2'h0};
	localparam logic [31:0] ADDR_BFC = {14'h0000, IDX_BRK_CTRL, 2'h0};
	localparam logic [31:0] ADDR_CFG = {14'h0000, IDX_SYS_CFG, 2'h0};

	typedef struct packed {
		rcs_state_t   state;
		logic [11:0]  cnt;
		logic [5:0]   sub;
		logic [6:0]   pin_low;
		logic         pin_m;
		logic         pin_s;
		logic [1:0]   div;
		logic [7:0]   cause;
		logic         stop_wait_break_flag;
		logic         break_flag_clear_enable;
		logic [2:0]   cfg;
		logic         pin_drv;
		rcs_apb_rsp_t apb;
		rcs_sys_out_t sys;
	} rcs_regs_t;

	rcs_regs_t q;
	rcs_regs_t d;

	logic       wdog_req;
	logic       opc_req;
	logic       adr_req;
	logic       int_req;
	logic       run_like;
	logic       acc;
	logic       wr_ok;
	logic [7:0] rd_byte;
	logic       hit;

	// request decode; reset sources outrank everything else
	always_comb begin
		wdog_req = i_sys.watchdog_ovf & ~q.cfg[CFG_WDOG_DIS];
		opc_req = i_sys.bad_opcode |
			(i_sys.stop_exec & ~q.cfg[CFG_STOP_EN] &
			 q.state == RCS_RUN);
		adr_req = i_sys.opcode_fetch & i_sys.unmapped_addr;
		run_like = q.state == RCS_RUN || q.state == RCS_WAIT ||
			q.state == RCS_STOP || q.state == RCS_STOPREC;
		int_req = run_like & (wdog_req | opc_req | adr_req);
	end

	// apb decode; one wait state, write lands with pready
	always_comb begin
		acc   = i_apb.psel & i_apb.penable;
		wr_ok = acc & q.apb.pready & i_apb.pwrite;
		hit   = 1'b1;
		rd_byte = 8'h00;
		case (i_apb.paddr)
			ADDR_BRK: rd_byte[BRK_SW_BIT] = q.stop_wait_break_flag;
			ADDR_RC:  rd_byte = q.cause;
			ADDR_BFC: rd_byte[BRK_CFE_BIT] = q.break_flag_clear_enable;
			ADDR_CFG: rd_byte[2:0] = q.cfg;
			default:  hit = 1'b0;
		endcase
	end

	// next state of the whole block
	always_comb begin
		d = q;
		d.pin_m = i_rst_pin;
		d.pin_s = q.pin_m;
		// counter free-runs unless a reset, stop entry or stop wake clears it
		d.cnt = q.cnt + 12'h001;
		d.sub = q.sub + 6'h01;
		d.div = q.div + 2'h1;

		// apb answer
		d.apb.pready  = acc & ~q.apb.pready;
		d.apb.prdata  = q.apb.prdata;
		d.apb.pslverr = 1'b0;
		if (acc & ~q.apb.pready) begin
			d.apb.prdata  = {24'h000000, rd_byte};
			d.apb.pslverr = ~hit;
		end
		if (wr_ok) begin
			if (i_apb.paddr == ADDR_BRK && !i_apb.pwdata[BRK_SW_BIT])
				d.stop_wait_break_flag = 1'b0;
			if (i_apb.paddr == ADDR_BFC)
				d.break_flag_clear_enable = i_apb.pwdata[BRK_CFE_BIT];
			if (i_apb.paddr == ADDR_CFG)
				d.cfg = i_apb.pwdata[2:0];
		end
		if (i_sys.stop_wait_break)
			d.stop_wait_break_flag = 1'b1;

		case (q.state)
			RCS_LONG: begin
				if (i_sys.low_supply)
					d.cnt = 12'h000;
				else if (q.cnt == LONG_LAST) begin
					d.state = RCS_DRIVE;
					d.sub   = 6'h00;
				end
			end
			RCS_DRIVE: begin
				if (q.sub == DRV_LAST) begin
					d.state   = RCS_HOLD;
					d.sub     = 6'h00;
					d.pin_drv = 1'b0;
				end
			end
			RCS_HOLD: begin
				if (q.sub == HOLD_LAST)
					d.state = RCS_RUN;
			end
			RCS_EXT: begin
				if (q.pin_low != QUAL_CNT)
					d.pin_low = q.pin_low + 7'h01;
				if (q.pin_s) begin
					d.state = RCS_HOLD;
					d.sub   = 6'h00;
					if (q.pin_low == QUAL_CNT)
						d.cause[CAUSE_PIN] = 1'b1;
				end
			end
			RCS_RUN: begin
				if (i_sys.stop_exec && q.cfg[CFG_STOP_EN]) begin
					d.state = RCS_STOP;
					d.cnt   = 12'h000;
				end else if (i_sys.wait_exec)
					d.state = RCS_WAIT;
			end
			RCS_WAIT: begin
				if (i_sys.wake)
					d.state = RCS_RUN;
			end
			RCS_STOP: begin
				if (i_sys.wake) begin
					d.state = RCS_STOPREC;
					d.cnt   = 12'h000;
				end
			end
			RCS_STOPREC: begin
				if ((q.cfg[CFG_SHORT_SR] && q.cnt == SHORT_LAST) ||
				    (!q.cfg[CFG_SHORT_SR] && q.cnt == LONG_LAST))
					d.state = RCS_RUN;
			end
			default: d.state = RCS_LONG;
		endcase

		// external pin low seen while running
		if (run_like && !q.pin_s && !int_req) begin
			d.state   = RCS_EXT;
			d.pin_low = 7'h01;
		end
		if (int_req) begin
			d.state   = RCS_DRIVE;
			d.sub     = 6'h00;
			d.pin_drv = 1'b1;
			d.cnt     = 12'h000;
			if (wdog_req) d.cause[CAUSE_WDOG] = 1'b1;
			if (opc_req)  d.cause[CAUSE_OPC]  = 1'b1;
			if (adr_req)  d.cause[CAUSE_ADR]  = 1'b1;
		end
		// low supply takes the long path
		if (i_sys.low_supply && q.state != RCS_LONG) begin
			d.state   = RCS_LONG;
			d.cnt     = 12'h000;
			d.pin_drv = 1'b1;
			d.cause[CAUSE_LVS] = 1'b1;
		end
		if (i_sys.power_on_pulse) begin
			d.state   = RCS_LONG;
			d.cnt     = 12'h000;
			d.pin_drv = 1'b1;
			d.cause   = 8'h00;
			d.cause[CAUSE_POR] = 1'b1;
		end

		if (d.state != RCS_RUN && d.state != RCS_WAIT &&
		    d.state != RCS_STOP && d.state != RCS_STOPREC) begin
			d.stop_wait_break_flag = 1'b0;
			d.break_flag_clear_enable = 1'b0;
		end

		d.sys.internal_reset = d.state == RCS_LONG ||
			d.state == RCS_DRIVE || d.state == RCS_HOLD ||
			d.state == RCS_EXT;
		d.sys.reset_vector = i_sys.monitor_mode ? VEC_MON : VEC_USER;
		d.sys.cpu_clk_en    = d.state == RCS_RUN;
		d.sys.periph_clk_en = d.state == RCS_RUN ||
			(d.state == RCS_WAIT && i_sys.periph_wait_active);
		d.sys.bus_clk_en = d.sys.periph_clk_en && q.div == BUS_DIV_LAST;
		d.sys.clkgen_output_en = d.state != RCS_STOP;
		d.sys.break_clear_en = d.break_flag_clear_enable;
	end

	// single register stage; power-on sequence after reset
	always_ff @(posedge i_mclk) begin
		if (!i_nrst) begin
			q <= '0;
			q.state   <= RCS_LONG;
			q.pin_m   <= 1'b1;
			q.pin_s   <= 1'b1;
			q.pin_drv <= 1'b1;
			q.cfg     <= CFG_RESET;
			q.cause[CAUSE_POR] <= 1'b1;
			q.sys.internal_reset   <= 1'b1;
			q.sys.clkgen_output_en <= 1'b1;
			q.sys.reset_vector     <= VEC_USER;
		end else begin
			q <= d;
		end
	end

	// open-drain pin: enable low means driving low
	assign o_rst_pin      = 1'b0;
	assign o_rst_pin_oe_n = ~q.pin_drv;
	assign o_apb          = q.apb;
	assign o_sys          = q.sys;
endmodule // rcs_sequencer
`default_nettype wire
